// ===== hdl/imf_cfg.svh
// Register map, field positions and reset values of the interrupt mask and flag block
//Contract
//[R1] Source mask nibble: keys, serial, converter
//[R2] Timer mask nibble: 1, 2, 16, 32 Hz
//[R3] Upper key flag at bit 0
//[R4] Lower key flag at bit 0
//[R5] Serial event flag at bit 0
//[R6] Four timer tap flags in one nibble
//[R7] Converter event flag at bit 0
//[R8] Reading a flag clears it
//[R9] Unused flag bits read zero, ignore writes
//[R10] Request high while enabled flag pending
`ifndef IMF_CFG_SVH
`define IMF_CFG_SVH
`define IMF_OFF_SRC_MASK   8'hf0
`define IMF_OFF_TAP_MASK   8'hf1
`define IMF_OFF_UKEY_FLAG  8'hf2
`define IMF_OFF_LKEY_FLAG  8'hf3
`define IMF_OFF_SER_FLAG   8'hf4
`define IMF_OFF_TAP_FLAG   8'hf5
`define IMF_OFF_CONV_FLAG  8'hf6
`define IMF_OFF_IRQ_STAT   8'hf8
`define IMF_OFF_IRQ_MASK   8'hf9
`define IMF_NIB_RESET      4'h0
`define IMF_EVT_RESET      8'h00
`define IMF_BIT_UKEY       7
`define IMF_BIT_LKEY       6
`define IMF_BIT_SER        5
`define IMF_BIT_CONV       4
`define IMF_BIT_T1         3
`define IMF_BIT_T2         2
`define IMF_BIT_T16        1
`define IMF_BIT_T32        0
`define IMF_ADDR_LSB       2
`define IMF_ADDR_MSB       9
`endif

// ===== hdl/imf_pkg.sv
// Types shared by the interrupt mask and flag block
package imf_pkg;
  // Eight event sources, order matches the two mask nibbles {source, tap}
  typedef struct packed {
    logic upper_key;
    logic lower_key;
    logic serial;
    logic converter;
    logic tap_1hz;
    logic tap_2hz;
    logic tap_16hz;
    logic tap_32hz;
  } imf_events_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } imf_access_t;
endpackage

// ===== hdl/imf_sticky.sv
// Bank of sticky flags with read clear, hardware set winning over clear
`timescale 1ns/100ps
`default_nettype none
`include "imf_cfg.svh"
module imf_sticky #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  output logic      [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flag_reg;
  logic [WIDTH-1:0] flag_next;

  // An event landing in the clearing read is kept for the next read
  assign flag_next = set_in | (flag_reg & ~clr_in);  // [R8]
  assign flags     = flag_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/imf_top.sv
// Interrupt mask and factor flag block with APB register access
`timescale 1ns/100ps
`default_nettype none
`include "imf_cfg.svh"
module imf_top (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire imf_pkg::imf_events_t event_in,
  output logic                     cpu_irq,
  output logic                     irq
);
  logic [3:0]  src_mask_reg;
  logic [3:0]  tap_mask_reg;
  logic [7:0]  irq_mask_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        cpu_irq_reg;
  logic        irq_reg;
  logic [7:0]  evt_seen_reg;

  imf_pkg::imf_access_t acc;
  logic [7:0]  flags;
  logic [7:0]  flag_clr;
  logic [7:0]  stat_bits;
  logic [7:0]  stat_clr;
  logic [7:0]  stat_set;
  logic [7:0]  enable_bits;
  logic        addr_ok;
  logic        is_src_mask;
  logic        is_tap_mask;
  logic        is_ukey;
  logic        is_lkey;
  logic        is_ser;
  logic        is_tap_flag;
  logic        is_conv;
  logic        is_stat;
  logic        is_imask;
  logic        mapped;
  logic        setup;
  logic        access;
  logic [31:0] rd_word;

  function automatic logic [31:0] nib(input logic [3:0] v);
    nib = {28'h000_0000, v};
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Answer in the first access cycle: zero wait states
  // Read data and read clear are taken together at the setup edge, so an event
  // arriving between the two phases is never lost; writes land when pready is seen
  assign setup  = psel & ~penable;
  assign access = psel & penable & pready_reg;
  assign acc    = '{wr:    access & pwrite,
                    rd:    setup & ~pwrite,
                    addr:  paddr[`IMF_ADDR_MSB:`IMF_ADDR_LSB],
                    wdata: pwdata};
  assign addr_ok   = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);

  assign is_src_mask = addr_ok & hit(acc.addr, `IMF_OFF_SRC_MASK);
  assign is_tap_mask = addr_ok & hit(acc.addr, `IMF_OFF_TAP_MASK);
  assign is_ukey     = addr_ok & hit(acc.addr, `IMF_OFF_UKEY_FLAG);
  assign is_lkey     = addr_ok & hit(acc.addr, `IMF_OFF_LKEY_FLAG);
  assign is_ser      = addr_ok & hit(acc.addr, `IMF_OFF_SER_FLAG);
  assign is_tap_flag = addr_ok & hit(acc.addr, `IMF_OFF_TAP_FLAG);
  assign is_conv     = addr_ok & hit(acc.addr, `IMF_OFF_CONV_FLAG);
  assign is_stat     = addr_ok & hit(acc.addr, `IMF_OFF_IRQ_STAT);
  assign is_imask    = addr_ok & hit(acc.addr, `IMF_OFF_IRQ_MASK);
  assign mapped      = is_src_mask | is_tap_mask | is_ukey | is_lkey | is_ser
                     | is_tap_flag | is_conv | is_stat | is_imask;

  // Factor flags, one bank, cleared by reading their own register
  // Bit order follows the event struct: keys, serial, converter, then the four taps
  assign flag_clr = {acc.rd & is_ukey,
                     acc.rd & is_lkey,
                     acc.rd & is_ser,
                     acc.rd & is_conv,
                     {4{acc.rd & is_tap_flag}}};  // [R8]

  imf_sticky #(
    .WIDTH (8)
  ) u_factor (
    .pclk    (pclk),
    .presetn (presetn),
    .set_in  (event_in),  // [R3] [R4] [R5] [R6] [R7]
    .clr_in  (flag_clr),
    .flags   (flags)
  );

  // Block status: event arrivals (rising edge of each event line)
  assign stat_set = event_in & ~evt_seen_reg;
  assign stat_clr = {8{acc.rd & is_stat}};

  imf_sticky #(
    .WIDTH (8)
  ) u_status (
    .pclk    (pclk),
    .presetn (presetn),
    .set_in  (stat_set),
    .clr_in  (stat_clr),
    .flags   (stat_bits)
  );

  assign enable_bits = {src_mask_reg, tap_mask_reg};

  // Unused flag bits read zero and writes to flag registers are dropped
  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_src_mask) begin
      rd_word = nib(src_mask_reg);  // [R1]
    end else if (is_tap_mask) begin
      rd_word = nib(tap_mask_reg);  // [R2]
    end else if (is_ukey) begin
      rd_word = nib({3'b000, flags[`IMF_BIT_UKEY]});  // [R3] [R9]
    end else if (is_lkey) begin
      rd_word = nib({3'b000, flags[`IMF_BIT_LKEY]});  // [R4] [R9]
    end else if (is_ser) begin
      rd_word = nib({3'b000, flags[`IMF_BIT_SER]});  // [R5] [R9]
    end else if (is_tap_flag) begin
      rd_word = nib(flags[3:0]);  // [R6]
    end else if (is_conv) begin
      rd_word = nib({3'b000, flags[`IMF_BIT_CONV]});  // [R7] [R9]
    end else if (is_stat) begin
      rd_word = {24'h00_0000, stat_bits};
    end else if (is_imask) begin
      rd_word = {24'h00_0000, irq_mask_reg};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_mask_reg <= `IMF_NIB_RESET;
      tap_mask_reg <= `IMF_NIB_RESET;
      irq_mask_reg <= `IMF_EVT_RESET;
    end else begin
      if (acc.wr & is_src_mask) begin
        src_mask_reg <= acc.wdata[3:0];  // [R1]
      end
      if (acc.wr & is_tap_mask) begin
        tap_mask_reg <= acc.wdata[3:0];  // [R2]
      end
      if (acc.wr & is_imask) begin
        irq_mask_reg <= acc.wdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~mapped;
      prdata_reg  <= acc.rd ? rd_word : 32'h0000_0000;
    end
  end

  // Registered request trails the flags by one cycle, keeping outputs glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq_reg  <= 1'b0;
      irq_reg      <= 1'b0;
      evt_seen_reg <= `IMF_EVT_RESET;
    end else begin
      cpu_irq_reg  <= |(flags & enable_bits);  // [R10]
      irq_reg      <= |(stat_bits & irq_mask_reg);
      evt_seen_reg <= event_in;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign cpu_irq = cpu_irq_reg;
  assign irq     = irq_reg;
endmodule
`default_nettype wire

// ===== verif/imf_cpu_model.sv
// CPU side register master model
`timescale 1ns/100ps
`default_nettype none
module imf_cpu_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // Request held until pready is seen; bounded so a dead slave ends the run
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output bit ok);
    ok = 1'b0;
    rd = '0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        rd = prdata;
        ok = 1'b1;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ===== verif/imf_assertions.sv
// Port checker for the interrupt mask and flag block
`timescale 1ns/100ps
`default_nettype none
module imf_checker (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire imf_pkg::imf_events_t event_in,
  input wire logic                 cpu_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd_ser = psel && !penable && !pwrite && paddr[9:2] == 8'hf4;
  wire logic flag_rd = pready && !pwrite && paddr[9:2] inside {[8'hf2:8'hf6]};
  sequence s_ser_read;
    rd_ser;
  endsequence
  sequence s_quiet;
    !event_in.serial && !rd_ser;
  endsequence
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("ready late");
  a_data_quiet: assert property (!pready |-> prdata == '0)
    else $error("data outside access");
  a_unmapped_err: assert property (pready && !(paddr[9:2] inside {[8'hf0:8'hf6], 8'hf8,
    8'hf9}) |-> pslverr && prdata == '0) else $error("unmapped not refused");
  a_unused_zero: assert property (flag_rd |-> prdata[31:4] == '0)
    else $error("unused bits set");
  a_flag_set: assert property (event_in.serial ##1 s_ser_read |=> prdata == 32'h0000_0001)
    else $error("event not latched");
  a_flag_clears: assert property ((rd_ser && !event_in.serial) ##1 s_quiet[*2]
    ##1 s_ser_read |=> prdata == '0) else $error("flag not cleared");
  a_irq_rise: assert property ($rose(cpu_irq) |-> $past(|event_in, 2)
    || $past(psel && pwrite, 2)) else $error("request without cause");
  a_irq_fall: assert property ($fell(cpu_irq) |-> $past(psel && (!penable || pwrite), 2))
    else $error("request dropped without access");
endmodule
bind imf_top imf_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .event_in(event_in), .cpu_irq(cpu_irq));
`default_nettype wire

// ===== verif/interrupt_mask_and_factor_flags_tb_top.sv
// Register-sequence bench for the interrupt mask and flag block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module interrupt_mask_and_factor_flags_tb_top;
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b0;
  wire logic            psel, penable, pwrite, pready, pslverr, cpu_irq, irq;
  wire logic [11:0]     paddr;
  wire logic [31:0]     pwdata, prdata;
  imf_pkg::imf_events_t ev = '0;
  logic [31:0]          rd;
  int                   miscompares = 0;
  int                   samples_checked = 0;
  always #10 pclk = ~pclk;
  imf_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_in(ev), .cpu_irq(cpu_irq), .irq(irq));
  imf_cpu_model u_cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
  task automatic complete_run();
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    bit ok;
    u_cpu.xfer(w, idx, wd, rd, ok);
    if (!ok) begin
      miscompares++;
      complete_run();
    end
  endtask
  // One-cycle event; returns on the sampling edge so a read can follow at once
  task automatic pulse(input logic [7:0] v);
    ev <= v;
    @(posedge pclk);
    ev <= '0;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 8'hf0; i < 8'hf7; i++) begin
      acc(1'b0, 8'(i), '0);
      `CHK(rd, 32'h0000_0000)
      acc(1'b1, 8'(i), 32'hffff_ffff);
    end
    for (int i = 8'hf0; i < 8'hf7; i++) begin
      acc(1'b0, 8'(i), '0);
      `CHK(rd, (i < 8'hf2) ? 32'h0000_000f : 32'h0000_0000)
    end
    pulse(8'hff);
    repeat (2) @(posedge pclk);
    `CHK(cpu_irq, 1'b1)
    for (int i = 8'hf2; i < 8'hf7; i++) begin
      acc(1'b0, 8'(i), '0);
      `CHK(rd, (i == 8'hf5) ? 32'h0000_000f : 32'h0000_0001)
      acc(1'b0, 8'(i), '0);
      `CHK(rd, 32'h0000_0000)
    end
    `CHK(cpu_irq, 1'b0)
    acc(1'b1, 8'hf0, '0);
    acc(1'b1, 8'hf1, '0);
    pulse(8'hff);
    repeat (2) @(posedge pclk);
    `CHK(cpu_irq, 1'b0)
    acc(1'b1, 8'hf1, 32'h0000_0004);
    // The mask lands at the access edge and the request one edge later
    @(negedge pclk);
    `CHK(cpu_irq, 1'b1)
    @(posedge pclk);
    acc(1'b0, 8'hf5, '0);
    `CHK(cpu_irq, 1'b0)
    pulse(8'h20);
    acc(1'b0, 8'hf4, '0);
    `CHK(rd, 32'h0000_0001)
    acc(1'b0, 8'hf7, '0);
    acc(1'b0, 8'hf8, '0);
    acc(1'b1, 8'hf9, 32'h0000_0020);
    pulse(8'h20);
    repeat (4) @(posedge pclk);
    `CHK(irq, 1'b1)
    acc(1'b0, 8'hf8, '0);
    `CHK(rd, 32'h0000_0020)
    `CHK(irq, 1'b0)
    acc(1'b1, 8'hf9, '0);
    pulse(8'h20);
    repeat (4) @(posedge pclk);
    `CHK(irq, 1'b0)
    complete_run();
  end
endmodule
`default_nettype wire
